/* File: rtl/msm_pkg.sv */
package msm_pkg;

    // ==================================================================
    // Clock, tick and bus widths
    // ==================================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TW = 20;
    localparam int AW = 8;
    localparam int DW = 32;

    // ==================================================================
    // Fixed times, in milliseconds, and their tick counts
    // ==================================================================
    localparam int OFF_DELAY_MS = 50;
    localparam int FLASH_HALF_MS = 500;
    localparam logic [5:0] OFF_DELAY_TICKS = 6'(OFF_DELAY_MS / TICK_MS);
    localparam logic [8:0] FLASH_TICKS = 9'(FLASH_HALF_MS / TICK_MS);

    // ==================================================================
    // Default time limits per mode
    // ==================================================================
    localparam int L_PAIR_S = 3;
    localparam int T_PAIR_S = 4;
    localparam int F_PAIR_S = 4;
    localparam int GAP_MIN_MS = 50;
    localparam int MUTE_MAX_MIN = 5;
    localparam int OVR_MAX_S = 20;
    localparam int L_FIELD_S = 3;
    localparam int T_FIELD_S = 4;
    localparam int F_FIELD_S = 5;

    // ==================================================================
    // Register offsets and status fields
    // ==================================================================
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_PAIR = 8'h04;
    localparam logic [AW-1:0] OFS_GAP = 8'h08;
    localparam logic [AW-1:0] OFS_MUTE = 8'h0c;
    localparam logic [AW-1:0] OFS_OVR = 8'h10;
    localparam logic [AW-1:0] OFS_FIELD = 8'h14;
    localparam logic [AW-1:0] OFS_STATUS = 8'h18;
    localparam int STS_STATE = 0;
    localparam int STS_MUTED = 3;
    localparam int STS_SAFETY = 4;
    localparam int STS_OVR = 5;
    localparam int STS_TERR = 6;
    localparam int STS_SERR = 7;
    localparam int STS_LAMP = 8;
    localparam int STS_INPUTS = 9;

    typedef enum logic [1:0] {
        MODE_L = 2'b00,
        MODE_TEN = 2'b01,
        MODE_FOUR = 2'b10
    } msm_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FIRST = 3'b001,
        ST_MUTED = 3'b010,
        ST_DONE = 3'b011,
        ST_ERROR = 3'b100
    } msm_state_t;

    // Filtered sensor and field levels, one bit each, high when active.
    typedef struct packed {
        logic outer_a;
        logic inner_a;
        logic inner_b;
        logic outer_b;
        logic upstream;
        logic downstream;
        logic field;
    } msm_in_t;

    // Time limits, all in ticks.
    typedef struct packed {
        logic [TW-1:0] pair;
        logic [TW-1:0] gap;
        logic [TW-1:0] mute;
        logic [TW-1:0] ovr;
        logic [TW-1:0] field;
    } msm_cfg_t;

    function automatic logic [TW-1:0] msm_ms(input int ms);
        return TW'(ms / TICK_MS);
    endfunction : msm_ms

    function automatic msm_cfg_t msm_defaults(input msm_mode_t m);
        msm_cfg_t c;
        c.gap = msm_ms(GAP_MIN_MS);
        c.mute = msm_ms(MUTE_MAX_MIN * 60000);
        c.ovr = msm_ms(OVR_MAX_S * 1000);
        c.pair = msm_ms(F_PAIR_S * 1000);
        c.field = msm_ms(F_FIELD_S * 1000);
        if (m == MODE_L) begin
            c.pair = msm_ms(L_PAIR_S * 1000);
            c.field = msm_ms(L_FIELD_S * 1000);
        end else if (m == MODE_TEN) begin
            c.pair = msm_ms(T_PAIR_S * 1000);
            c.field = msm_ms(T_FIELD_S * 1000);
        end
        return c;
    endfunction : msm_defaults

endpackage : msm_pkg

/* File: rtl/msm_monitor.sv */
`timescale 1ns/1ns

// Overview of operation
// R1: L mode mutes only if both sensors activate within the pair window.
// R2: L muting ends on field timeout, field clear or maximum mute time.
// R3: L defaults: 3 s pair, 50 ms gap, 5 min, 20 s, 3 s; adjustable.
// R4: Enable mode starts a sequence only while the conveyor enable is low.
// R5: Enable mode mutes only while enable plus the leading side sensor hold.
// R6: Enable mode sets no limit between enable low and side sensor low.
// R7: Enable mode needs both side sensors within pair window, under mute max.
// R8: Enable mode ends when the active pair drops or mute max expires.
// R9: New enable sequence only after enable goes high then low again.
// R10: Enable defaults: 4 s pair, 5 min mute, 20 s override, 4 s field.
// R11: Enable timing error flashes lamp at 1 Hz and raises timing error.
// R12: Object stalled at first sensor: error, flashing, safety pair stays on.
// R13: Enable going high clears timing, sequence and muting errors.
// R14: Four-sensor mode works both ways; mutes once second sensor blocks.
// R15: Four-sensor first two within pair window, spaced above minimum gap.
// R16: Four-sensor sequence succeeds only with all four active together.
// R17: Four-sensor muting ends when a last sensor drops or mute max expires.
// R18: Four defaults: 4 s pair, 50 ms gap, 5 min, 20 s, 5 s field.
// R19: Sensors and field interruption get a fixed 50 ms off-delay.
// R20: Lamp steady while muted, flashing on a sequence error.
// R21: Field interrupted without valid muting switches the safety pair off.
// R22: Override re-enables outputs until its limit or the field clears.
// R23: Time limits are tick counters from registers, restarted per sequence.
// R24: One mode is selected; a mode change or reset returns to idle.
module msm_monitor #(
    parameter int TICK_CYCLES = msm_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Register port.
    input wire logic [msm_pkg::AW-1:0] reg_addr,
    input wire logic [msm_pkg::DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [msm_pkg::DW-1:0] reg_rdata,
    // Sensor and field inputs, high when active.
    input wire logic mute_sensor_outer_a,
    input wire logic mute_sensor_inner_a,
    input wire logic mute_sensor_inner_b,
    input wire logic mute_sensor_outer_b,
    input wire logic side_sensor_upstream,
    input wire logic side_sensor_downstream,
    input wire logic protective_field,
    // Conveyor enable, active low, and override button.
    input wire logic conveyor_enable_input_n,
    input wire logic override_button,
    // Outputs.
    output logic safety_output_pair,
    output logic mute_lamp,
    output logic muted,
    output logic mute_timing_error,
    output logic mute_sequence_error,
    output logic muting_error
);

    // ==================================================================
    // Tick divider and off-delay filters
    // ==================================================================
    logic [31:0] div_q;
    logic tick;
    msm_pkg::msm_in_t raw, f;
    logic [6:0] raw_v, f_v;
    // One enable pulse per tick; every time limit counts these.
    always_ff @(posedge core_clk) begin
        if (reset || div_q == 32'(TICK_CYCLES - 1)) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
    assign tick = (div_q == 32'(TICK_CYCLES - 1));

    assign raw = '{mute_sensor_outer_a, mute_sensor_inner_a,
        mute_sensor_inner_b, mute_sensor_outer_b, side_sensor_upstream,
        side_sensor_downstream, protective_field};
    assign raw_v = raw;
    assign f = f_v;
    // Off-delay bridges short gaps in irregular loads; rising edges pass
    // at once so a real interruption is never delayed.
    for (genvar i = 0; i < 7; i++) begin : g_filt
        logic [5:0] hold_q;
        always_ff @(posedge core_clk) begin
            if (reset) begin
                hold_q <= 6'h0;
            end else if (raw_v[i]) begin
                hold_q <= msm_pkg::OFF_DELAY_TICKS; // R19
            end else if (tick && hold_q != 6'h0) begin
                hold_q <= hold_q - 6'h1;
            end
        end
        assign f_v[i] = raw_v[i] || hold_q != 6'h0;
    end

    // ==================================================================
    // Registers
    // ==================================================================
    msm_pkg::msm_mode_t mode_q;
    msm_pkg::msm_cfg_t cfg_q;
    logic mode_chg_q;
    logic [msm_pkg::DW-1:0] status;
    msm_pkg::msm_state_t state_q, state_d;
    logic ovr_q, terr_q, serr_q, flash_q, btn_q;

    // Writing the mode reloads that mode's default limits.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_q <= msm_pkg::MODE_L;
            cfg_q <= msm_pkg::msm_defaults(msm_pkg::MODE_L); // R3
            mode_chg_q <= 1'b0;
        end else begin
            mode_chg_q <= 1'b0;
            if (reg_write && reg_addr == msm_pkg::OFS_CTRL
                    && reg_wdata[1:0] != 2'b11) begin
                mode_q <= msm_pkg::msm_mode_t'(reg_wdata[1:0]); // R24
                cfg_q <= msm_pkg::msm_defaults(
                    msm_pkg::msm_mode_t'(reg_wdata[1:0])); // R10 R18
                mode_chg_q <= reg_wdata[1:0] != mode_q;
            end else if (reg_write) begin
                case (reg_addr)
                    msm_pkg::OFS_PAIR: cfg_q.pair <= reg_wdata[19:0];
                    msm_pkg::OFS_GAP: cfg_q.gap <= reg_wdata[19:0];
                    msm_pkg::OFS_MUTE: cfg_q.mute <= reg_wdata[19:0];
                    msm_pkg::OFS_OVR: cfg_q.ovr <= reg_wdata[19:0];
                    msm_pkg::OFS_FIELD: cfg_q.field <= reg_wdata[19:0];
                    default: ;
                endcase
            end
        end
    end
    always_comb begin
        status = '0;
        status[msm_pkg::STS_STATE +: 3] = state_q;
        status[msm_pkg::STS_MUTED] = muted;
        status[msm_pkg::STS_SAFETY] = safety_output_pair;
        status[msm_pkg::STS_OVR] = ovr_q;
        status[msm_pkg::STS_TERR] = terr_q;
        status[msm_pkg::STS_SERR] = serr_q;
        status[msm_pkg::STS_LAMP] = mute_lamp;
        status[msm_pkg::STS_INPUTS +: 7] = f_v;
    end
    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge core_clk) begin
        if (reset || !reg_read) begin
            reg_rdata <= '0;
        end else begin
            case (reg_addr)
                msm_pkg::OFS_CTRL: reg_rdata <= 32'(mode_q);
                msm_pkg::OFS_PAIR: reg_rdata <= 32'(cfg_q.pair);
                msm_pkg::OFS_GAP: reg_rdata <= 32'(cfg_q.gap);
                msm_pkg::OFS_MUTE: reg_rdata <= 32'(cfg_q.mute);
                msm_pkg::OFS_OVR: reg_rdata <= 32'(cfg_q.ovr);
                msm_pkg::OFS_FIELD: reg_rdata <= 32'(cfg_q.field);
                msm_pkg::OFS_STATUS: reg_rdata <= status;
                default: reg_rdata <= '0;
            endcase
        end
    end

    // ==================================================================
    // Sequence checker
    // ==================================================================
    logic dir_q, dir_d, restart, set_terr, set_serr;
    logic seen_q, all4_q, both_q, en_act, four, ten;
    logic lead, pair_ok, last_ok, pair_act, any_in;
    logic [msm_pkg::TW-1:0] seq_cnt_q, mute_cnt_q, field_cnt_q, ovr_cnt_q;

    assign en_act = !conveyor_enable_input_n;
    assign four = mode_q == msm_pkg::MODE_FOUR;
    assign ten = mode_q == msm_pkg::MODE_TEN;
    assign lead = four ? (dir_q ? f.outer_b : f.outer_a)
        : (f.outer_a || f.inner_a);
    assign pair_ok = four && dir_q ? (f.outer_b && f.inner_b)
        : (f.outer_a && f.inner_a);
    assign last_ok = dir_q ? (f.outer_a && f.inner_a)
        : (f.outer_b && f.inner_b);
    assign pair_act = en_act && (dir_q ? f.downstream : f.upstream); // R5
    assign any_in = |f_v[6:1];

    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        restart = 1'b0;
        set_terr = 1'b0;
        set_serr = 1'b0;
        case (state_q)
            msm_pkg::ST_IDLE: begin
                if (ten) begin
                    // No limit from enable to sensor; only both are needed.
                    if (en_act && (f.upstream || f.downstream)) begin // R4 R6
                        state_d = msm_pkg::ST_MUTED;
                        dir_d = !f.upstream;
                        restart = 1'b1; // R23
                    end
                end else if (four ? (f.outer_a || f.outer_b)
                        : (f.outer_a || f.inner_a)) begin
                    state_d = msm_pkg::ST_FIRST;
                    dir_d = four && !f.outer_a; // R14
                    restart = 1'b1; // R23
                end
            end
            msm_pkg::ST_FIRST: begin
                if (!lead) begin
                    state_d = msm_pkg::ST_IDLE;
                end else if (pair_ok) begin
                    if (seq_cnt_q < cfg_q.gap) begin // R15
                        state_d = msm_pkg::ST_ERROR;
                        set_serr = 1'b1;
                    end else begin
                        state_d = msm_pkg::ST_MUTED; // R1 R14
                    end
                end else if (seq_cnt_q >= cfg_q.pair) begin // R1 R15
                    state_d = msm_pkg::ST_ERROR;
                    set_terr = 1'b1;
                end
            end
            msm_pkg::ST_MUTED: begin
                if (mute_cnt_q >= cfg_q.mute
                        || field_cnt_q >= cfg_q.field) begin // R2 R8 R17
                    state_d = msm_pkg::ST_ERROR;
                    set_terr = 1'b1;
                end else if (ten) begin
                    if (!pair_act) begin // R8
                        state_d = both_q ? msm_pkg::ST_DONE
                            : msm_pkg::ST_ERROR;
                        set_serr = !both_q;
                    end else if (!both_q && seq_cnt_q >= cfg_q.pair) begin
                        state_d = msm_pkg::ST_ERROR; // R7 R12
                        set_terr = 1'b1; // R11
                    end
                end else if (four) begin
                    if (all4_q && !last_ok) begin // R17
                        state_d = msm_pkg::ST_DONE;
                    end else if (!all4_q && !pair_ok) begin // R16
                        state_d = msm_pkg::ST_ERROR;
                        set_serr = 1'b1;
                    end
                end else if (seen_q && !f.field) begin // R2
                    state_d = msm_pkg::ST_DONE;
                end
            end
            msm_pkg::ST_DONE, msm_pkg::ST_ERROR: begin
                // Enable mode rearms only on enable high; others wait
                // for the material to clear every sensor and the field.
                if (ten ? !en_act : !(any_in || f.field)) begin // R9
                    state_d = msm_pkg::ST_IDLE;
                end
            end
            default: state_d = msm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset || mode_chg_q) begin
            state_q <= msm_pkg::ST_IDLE; // R24
            dir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dir_q <= dir_d;
        end
    end
    // Progress flags within one muted period.
    always_ff @(posedge core_clk) begin
        if (reset || state_q != msm_pkg::ST_MUTED) begin
            seen_q <= 1'b0;
            all4_q <= 1'b0;
            both_q <= 1'b0;
        end else begin
            seen_q <= seen_q || f.field;
            all4_q <= all4_q || (&f_v[6:3]); // R16
            both_q <= both_q || (f.upstream && f.downstream); // R7
        end
    end

    // ==================================================================
    // Tick counters
    // ==================================================================
    function automatic logic [msm_pkg::TW-1:0] sat_inc(
            input logic [msm_pkg::TW-1:0] v, input logic t);
        return (t && v != '1) ? v + 20'h1 : v;
    endfunction : sat_inc

    always_ff @(posedge core_clk) begin
        seq_cnt_q <= (reset || restart) ? '0 : sat_inc(seq_cnt_q, tick);
        mute_cnt_q <= (reset || !muted) ? '0 : sat_inc(mute_cnt_q, tick);
        field_cnt_q <= (reset || !(muted && f.field)) ? '0
            : sat_inc(field_cnt_q, tick);
        ovr_cnt_q <= (reset || !ovr_q) ? '0 : sat_inc(ovr_cnt_q, tick);
    end

    // ==================================================================
    // Errors, override and outputs
    // ==================================================================
    logic [8:0] flash_cnt_q;
    logic clr_err;

    // A set in the same cycle as a clear wins, so no event is lost.
    assign clr_err = ten ? !en_act // R13
        : (state_q == msm_pkg::ST_ERROR && state_d == msm_pkg::ST_IDLE);
    always_ff @(posedge core_clk) begin
        if (reset || mode_chg_q) begin
            terr_q <= 1'b0;
            serr_q <= 1'b0;
        end else begin
            terr_q <= set_terr || (terr_q && !clr_err); // R11
            serr_q <= set_serr || (serr_q && !clr_err);
        end
    end
    // Half period of 500 ms gives the 1 Hz flash.
    always_ff @(posedge core_clk) begin
        if (reset || !(terr_q || serr_q)) begin
            flash_cnt_q <= 9'h0;
            flash_q <= 1'b1;
        end else if (tick) begin
            if (flash_cnt_q == msm_pkg::FLASH_TICKS - 9'h1) begin
                flash_cnt_q <= 9'h0;
                flash_q <= !flash_q; // R11
            end else begin
                flash_cnt_q <= flash_cnt_q + 9'h1;
            end
        end
    end
    // A fresh press while the field blocks arms it; holding cannot extend it.
    always_ff @(posedge core_clk) begin
        btn_q <= override_button && !reset;
        if (reset || !f.field || (ovr_q && ovr_cnt_q >= cfg_q.ovr)) begin
            ovr_q <= 1'b0; // R22
        end else if (override_button && !btn_q && !muted) begin
            ovr_q <= 1'b1; // R22
        end
    end
    // A stalled object leaves the field clear, so outputs stay on.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            safety_output_pair <= 1'b0;
            mute_lamp <= 1'b0;
        end else begin
            safety_output_pair <= !(f.field && !muted && !ovr_q); // R21 R12
            mute_lamp <= (state_d == msm_pkg::ST_MUTED)
                || ((terr_q || serr_q) && flash_q); // R20
        end
    end

    assign muted = state_q == msm_pkg::ST_MUTED;
    assign mute_timing_error = terr_q;
    assign mute_sequence_error = serr_q;
    assign muting_error = terr_q || serr_q;

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_ten_high2;
        (ten && conveyor_enable_input_n) [*2];
    endsequence

    a_lamp_when_muted: assert property (muted |-> mute_lamp) // R20
        else $error("lamp dark while muted");
    a_field_offs_out: assert property ( // R21
        f.field && !muted && !ovr_q |=> !safety_output_pair)
        else $error("safety pair on with field interrupted");
    a_enable_gates_start: assert property ( // R4
        state_q == msm_pkg::ST_IDLE && ten && !en_act && !mode_chg_q
        |=> !muted)
        else $error("muting started without enable");
    a_gap_refused: assert property ( // R15
        state_q == msm_pkg::ST_FIRST && lead && pair_ok
        && seq_cnt_q < cfg_q.gap && !mode_chg_q
        |=> state_q == msm_pkg::ST_ERROR && mute_sequence_error)
        else $error("too short sensor gap accepted");
    a_pair_window: assert property ( // R1
        state_q == msm_pkg::ST_FIRST && lead && !pair_ok
        && seq_cnt_q >= cfg_q.pair && !mode_chg_q
        |=> mute_timing_error ##1 !muted)
        else $error("pair window overrun not flagged");
    a_mute_max_ends: assert property ( // R2
        muted && mute_cnt_q >= cfg_q.mute && !mode_chg_q
        |=> !muted && mute_timing_error)
        else $error("muting outlived maximum time");
    a_enable_clears: assert property ( // R13
        s_ten_high2 |=> !mute_timing_error && !muting_error)
        else $error("errors not cleared by enable high");
    a_override_limit: assert property ( // R22
        ovr_q && ovr_cnt_q >= cfg_q.ovr |=> !ovr_q)
        else $error("override outlived its limit");
    a_mode_to_idle: assert property ( // R24
        mode_chg_q |=> state_q == msm_pkg::ST_IDLE)
        else $error("mode change did not return to idle");
    a_off_delay_hold: assert property ( // R19
        $fell(protective_field) |-> f.field ##1 f.field)
        else $error("field release not delayed");

endmodule : msm_monitor

/* File: dv/msm_world.sv */
`timescale 1ns/1ns

// ============================================================
// Far side: muting sensors, field and conveyor enable.
module msm_world (
    // Clock.
    input wire logic core_clk,
    // Levels towards the block; lines high when active, enable_n low when active.
    output logic [6:0] lines,
    output logic enable_n
);
    // Idle at time zero: nothing detected, conveyor stopped.
    initial begin
        lines = 7'h00;
        enable_n = 1'b1;
    end

    // Levels move only just after an edge, as real sensors do.
    task automatic set(input logic [6:0] v, input logic en_n);
        @(posedge core_clk);
        lines <= v;
        enable_n <= en_n;
    endtask : set
endmodule : msm_world

/* File: dv/muting_sequence_monitor_bench.sv */
`timescale 1ns/1ns

// ============================================================
// Bench for the muting monitor, tick of four clocks.
module muting_sequence_monitor_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic ovr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [6:0] ln;
    logic en_n, safe, lamp, muted, terr, serr, merr;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    msm_monitor #(.TICK_CYCLES(4)) i_msm_monitor (.core_clk(core_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mute_sensor_outer_a(ln[6]), .mute_sensor_inner_a(ln[5]),
        .mute_sensor_inner_b(ln[4]), .mute_sensor_outer_b(ln[3]),
        .side_sensor_upstream(ln[2]), .side_sensor_downstream(ln[1]),
        .protective_field(ln[0]), .conveyor_enable_input_n(en_n),
        .override_button(ovr), .safety_output_pair(safe),
        .mute_lamp(lamp), .muted(muted), .mute_timing_error(terr),
        .mute_sequence_error(serr), .muting_error(merr));
    msm_world i_msm_world (.core_clk(core_clk), .lines(ln),
        .enable_n(en_n));

    // Free-running clock; a hang is cut short well past the plan.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask : rd
    task automatic wt(input int t);
        repeat (t * 4) @(posedge core_clk);
        #1;
    endtask : wt
    // Short limits keep the run brief; the off-delay stays 50 ticks.
    task automatic lim();
        wr(msm_pkg::OFS_PAIR, 32'd20);
        wr(msm_pkg::OFS_GAP, 32'd5);
        wr(msm_pkg::OFS_OVR, 32'd10);
    endtask : lim
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Main sequence: L, four-sensor, then enable mode.
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(msm_pkg::OFS_PAIR, 32'd3000);
        rd(8'h1c, 32'h0);
        lim();
        i_msm_world.set(7'h40, 1'b1);
        wt(10);
        i_msm_world.set(7'h60, 1'b1);
        wt(1);
        chk("muted", muted, 1);
        chk("lamp", lamp, 1);
        i_msm_world.set(7'h61, 1'b1);
        wt(2);
        chk("safe", safe, 1);
        i_msm_world.set(7'h60, 1'b1);
        wt(40);
        chk("muted", muted, 1);
        wt(20);
        chk("muted", muted, 0);
        i_msm_world.set(7'h00, 1'b1);
        wt(60);
        i_msm_world.set(7'h40, 1'b1);
        wt(30);
        chk("terr", terr, 1);
        i_msm_world.set(7'h41, 1'b1);
        wt(2);
        chk("safe", safe, 0);
        @(posedge core_clk) ovr <= 1'b1;
        wt(1);
        chk("safe", safe, 1);
        @(posedge core_clk) ovr <= 1'b0;
        wt(12);
        chk("safe", safe, 0);
        i_msm_world.set(7'h00, 1'b1);
        wt(60);
        chk("terr", terr, 0);
        wr(msm_pkg::OFS_CTRL, 32'd2);
        rd(msm_pkg::OFS_FIELD, 32'd5000);
        lim();
        i_msm_world.set(7'h60, 1'b1);
        wt(2);
        chk("serr", serr, 1);
        i_msm_world.set(7'h00, 1'b1);
        wt(60);
        i_msm_world.set(7'h08, 1'b1);
        wt(10);
        i_msm_world.set(7'h18, 1'b1);
        wt(1);
        chk("muted", muted, 1);
        i_msm_world.set(7'h78, 1'b1);
        wt(2);
        i_msm_world.set(7'h38, 1'b1);
        wt(55);
        chk("muted", muted, 0);
        chk("serr", serr, 0);
        i_msm_world.set(7'h00, 1'b1);
        wt(60);
        wr(msm_pkg::OFS_CTRL, 32'd1);
        rd(msm_pkg::OFS_PAIR, 32'd4000);
        i_msm_world.set(7'h04, 1'b1);
        wt(2);
        chk("muted", muted, 0);
        i_msm_world.set(7'h04, 1'b0);
        wt(1);
        chk("muted", muted, 1);
        i_msm_world.set(7'h00, 1'b0);
        wt(55);
        chk("muted", muted, 0);
        chk("serr", serr, 1);
        i_msm_world.set(7'h00, 1'b1);
        wt(2);
        chk("merr", merr, 0);
        lim();
        i_msm_world.set(7'h04, 1'b0);
        wt(25);
        chk("terr", terr, 1);
        chk("safe", safe, 1);
        chk("lamp", lamp, 1);
        wt(500);
        chk("lamp", lamp, 0);
        i_msm_world.set(7'h04, 1'b1);
        wt(2);
        chk("terr", terr, 0);
        i_msm_world.set(7'h04, 1'b0);
        wt(1);
        chk("muted", muted, 1);
        finish_test();
    end
endmodule : muting_sequence_monitor_bench
